// ==== hw/etc_ctrl.sv ====
// Purpose: Per-channel control of an event-driven single transfer mover
// Assumes: Arbitration gives one winning request per cycle
// Notes: Result of each request is reported one cycle later
`timescale 1ns/1ps
module etc_ctrl
#(
    parameter int NUM_CH = etc_pkg::NUM_CH
)
(
    input wire logic clk,
    input wire logic reset,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Arbitration winner
    input wire etc_pkg::etc_req_t req,
    // Result of the serviced request
    output etc_pkg::etc_act_t act,
    output logic end_transfer_node_request
);
    // Refuse channel counts that the pair logic cannot serve
    if (NUM_CH != 8)
    begin
        $error("etc_ctrl supports exactly eight channels");
    end

    // Every check below runs on the system clock, off during reset
    default clocking etc_cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic [15:0] ctrl_q [NUM_CH];
    logic [15:0] src_q [NUM_CH];
    logic [15:0] dst_q [NUM_CH];
    logic [15:0] seg_q [NUM_CH];
    logic [15:0] subnode_q;
    logic [NUM_CH/2-1:0] odd_act_q;
    etc_pkg::etc_act_t act_d;

    // Bus write handshake
    logic aw_held_q, w_held_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

    // Capture address and data independently
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_held_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            else if (wr_go)
                w_held_q <= 1'b0;
        end
    end

    // Readies are registered copies of the next free state
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !(s_axi_awvalid && s_axi_awready)
                             && !(aw_held_q && !wr_go);
            s_axi_wready <= !(s_axi_wvalid && s_axi_wready)
                            && !(w_held_q && !wr_go);
            s_axi_arready <= !(s_axi_arvalid && s_axi_arready)
                             && !(s_axi_rvalid && !s_axi_rready);
        end
    end

    // Decode the write target
    logic [2:0] wr_ch;
    logic [11:0] wr_sub;
    logic wr_chan_area, wr_hit;
    logic [15:0] wr_mask;
    assign wr_ch = awaddr_q[7:5];
    assign wr_sub = awaddr_q & 12'h01F;
    assign wr_chan_area = awaddr_q[11:8] == 4'h0;
    assign wr_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wr_hit = wr_chan_area ? (wr_sub[1:0] == 2'h0 && wr_sub < 12'h010)
                  : (awaddr_q == etc_pkg::SUBNODE_OFS
                     || awaddr_q == etc_pkg::ENDNODE_OFS);

    // Write response
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= etc_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? etc_pkg::RESP_OKAY : etc_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Per-request decode of the serviced channel
    logic [2:0] ch, eff;
    logic pair_linked, odd_blocked;
    logic [7:0] cnt;
    logic [15:0] cc;
    logic last;
    assign ch = req.chan;
    assign pair_linked = ctrl_q[{ch[2:1], 1'b0}][etc_pkg::LINK_BIT]
                       || ctrl_q[{ch[2:1], 1'b1}][etc_pkg::LINK_BIT];
    assign odd_blocked = ch[0] && pair_linked;
    // Linked pair: route via the active member
    assign eff = pair_linked ? {ch[2:1], odd_act_q[ch[2:1]]} : ch;
    assign cc = ctrl_q[eff];
    assign cnt = cc[etc_pkg::CNT_LSB +: 8];
    assign last = cnt == etc_pkg::CNT_ONE;

    // Saturating offset increment
    function automatic logic [15:0] bump(input logic [15:0] p,
                                         input logic word);
        logic [15:0] lim;
        lim = word ? etc_pkg::SAT_WORD : etc_pkg::SAT_BYTE;
        if (p >= lim)
            bump = p;
        else
            bump = p + (word ? 16'h0002 : 16'h0001);
    endfunction

    // Build the result of this request
    always_comb
    begin
        act_d = '0;
        act_d.valid = req.valid;
        act_d.word = !cc[etc_pkg::BWS_BIT];
        // Pointer composition, no page pointers
        act_d.src = {seg_q[eff][15:8], src_q[eff]};
        act_d.dst = {seg_q[eff][7:0], dst_q[eff]};
        if (req.valid)
        begin
            if (odd_blocked || cnt == etc_pkg::CNT_ZERO)
                act_d.normal_irq = 1'b1;
            else
            begin
                act_d.xfer = 1'b1;
                act_d.trap = act_d.word
                    && (src_q[eff][0] || dst_q[eff][0]);
                act_d.keep_req = last && !cc[etc_pkg::EOT_BIT]
                    && !cc[etc_pkg::LINK_BIT];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            act <= '0;
        else
            act <= act_d;
    end

    // Channel registers: software writes and hardware updates
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                ctrl_q[i] <= etc_pkg::CTRL_RST;
                src_q[i] <= etc_pkg::PTR_RST;
                dst_q[i] <= etc_pkg::PTR_RST;
                seg_q[i] <= etc_pkg::SEG_RST;
            end
        end
        else
        begin
            if (wr_go && wr_chan_area)
            begin
                case (wr_sub)
                    etc_pkg::CTRL_OFS: ctrl_q[wr_ch] <=
                        (ctrl_q[wr_ch] & ~wr_mask) | (wdata_q[15:0] & wr_mask);
                    etc_pkg::SRC_OFS: src_q[wr_ch] <= (src_q[wr_ch] & ~wr_mask)
                                      | (wdata_q[15:0] & wr_mask);
                    etc_pkg::DST_OFS: dst_q[wr_ch] <= (dst_q[wr_ch] & ~wr_mask)
                                      | (wdata_q[15:0] & wr_mask);
                    etc_pkg::SEG_OFS: seg_q[wr_ch] <= (seg_q[wr_ch] & ~wr_mask)
                                      | (wdata_q[15:0] & wr_mask);
                    default: ;
                endcase
            end
            // Hardware update wins over a same-cycle software write
            if (act_d.xfer)
            begin
                if (cnt != etc_pkg::CNT_CONT)
                    ctrl_q[eff][etc_pkg::CNT_LSB +: 8] <= cnt - 8'h01;
                if (cc[etc_pkg::INC_LSB +: 2] != 2'h0)
                begin
                    if (cc[etc_pkg::INC_LSB])
                        dst_q[eff] <= bump(dst_q[eff], act_d.word);
                    if (cc[etc_pkg::INC_LSB + 1])
                        src_q[eff] <= bump(src_q[eff], act_d.word);
                end
            end
        end
    end

    // Active member of each pair
    always_ff @(posedge clk)
    begin
        if (reset)
            odd_act_q <= '0;
        else
        begin
            for (int p = 0; p < NUM_CH / 2; p++)
            begin
                logic l0, l1, z0, z1;
                l0 = ctrl_q[2*p][etc_pkg::LINK_BIT];
                l1 = ctrl_q[2*p+1][etc_pkg::LINK_BIT];
                z0 = ctrl_q[2*p][7:0] == etc_pkg::CNT_ZERO;
                z1 = ctrl_q[2*p+1][7:0] == etc_pkg::CNT_ZERO;
                if (act_d.xfer && last && eff[2:1] == p[1:0]
                    && cc[etc_pkg::LINK_BIT])
                    odd_act_q[p] <= ~odd_act_q[p];
                else if ((!l0 && !l1) || (z0 && z1))
                    odd_act_q[p] <= 1'b0;
            end
        end
    end

    // Sub-node flags and end node request
    logic eot_fire;
    assign eot_fire = act_d.xfer && last
                    && (cc[etc_pkg::EOT_BIT] || cc[etc_pkg::LINK_BIT]);
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            subnode_q <= 16'h0000;
            end_transfer_node_request <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (eot_fire && eff == i[2:0])
                    subnode_q[2*i+1] <= 1'b1;
                else if (wr_go && awaddr_q == etc_pkg::SUBNODE_OFS
                         && wstrb_q[i/4])
                    subnode_q[2*i+1] <= wdata_q[2*i+1];
                if (wr_go && awaddr_q == etc_pkg::SUBNODE_OFS && wstrb_q[i/4])
                    subnode_q[2*i] <= wdata_q[2*i];
            end
            if (eot_fire && subnode_q[2*eff])
                end_transfer_node_request <= 1'b1;
            else if (wr_go && awaddr_q == etc_pkg::ENDNODE_OFS && wstrb_q[0])
                end_transfer_node_request <= wdata_q[0];
        end
    end

    // Read path
    logic [31:0] rd_d;
    logic [2:0] rd_ch;
    logic rd_ok;
    assign rd_ch = s_axi_araddr[7:5];
    always_comb
    begin
        rd_d = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr[11:8] == 4'h0 && s_axi_araddr[4] == 1'b0)
        begin
            case (s_axi_araddr & 12'h01F)
                etc_pkg::CTRL_OFS: rd_d[15:0] = ctrl_q[rd_ch];
                etc_pkg::SRC_OFS: rd_d[15:0] = src_q[rd_ch];
                etc_pkg::DST_OFS: rd_d[15:0] = dst_q[rd_ch];
                etc_pkg::SEG_OFS: rd_d[15:0] = seg_q[rd_ch];
                default: rd_ok = 1'b0;
            endcase
        end
        else if (s_axi_araddr == etc_pkg::SUBNODE_OFS)
            rd_d[15:0] = subnode_q;
        else if (s_axi_araddr == etc_pkg::ENDNODE_OFS)
            rd_d[0] = end_transfer_node_request;
        else if (s_axi_araddr == etc_pkg::STATUS_OFS)
            rd_d[3:0] = odd_act_q;
        else
            rd_ok = 1'b0;
    end

    // Read response, one outstanding read
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= etc_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_ok ? etc_pkg::RESP_OKAY : etc_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks on request outcomes, segment stability and pair fallback
    AST_ZERO_NORMAL: assert property (
        req.valid && cnt == 8'h00 |=> act.normal_irq && !act.xfer)
        else $error("zero count request did not give normal interrupt");
    AST_ODD_BLOCK: assert property (
        req.valid && odd_blocked |=> act.normal_irq && !act.xfer)
        else $error("odd channel of linked pair transferred");
    AST_KEEP_REQ: assert property (
        act_d.xfer && last && !cc[11] && !cc[12] |=> act.keep_req)
        else $error("request flag not kept at count end");
    AST_LINK_EOT: assert property (
        act_d.xfer && last && cc[12]
        |=> !act.keep_req && subnode_q[2*$past(eff)+1])
        else $error("linked channel end did not raise end interrupt");
    AST_MID_QUIET: assert property (
        act_d.xfer && cnt > 8'h01 |=> !act.keep_req && !act.normal_irq)
        else $error("interrupt activity during mid transfer");
    AST_SUBNODE: assert property (
        eot_fire |=> subnode_q[2*$past(eff)+1])
        else $error("sub-node flag not set");
    AST_SEG_FIXED: assert property (
        !wr_go |=> seg_q[0] == $past(seg_q[0]))
        else $error("segment changed by hardware");
    AST_SAT: assert property (
        act_d.xfer && src_q[eff] == 16'hFFFF && !wr_go
        |=> src_q[$past(eff)] == 16'hFFFF)
        else $error("source offset wrapped");
    AST_TOGGLE: assert property (
        act_d.xfer && last && cc[12] && eff[2:1] == 2'h0
        |=> odd_act_q[0] != $past(odd_act_q[0]))
        else $error("linked pair did not toggle");
    AST_EVEN_FORCE: assert property (
        (ctrl_q[0][7:0] == 8'h00 && ctrl_q[1][7:0] == 8'h00)
        || (!ctrl_q[0][12] && !ctrl_q[1][12]) |=> !odd_act_q[0])
        else $error("pair did not fall back to even channel");
    AST_SRC_ADDR: assert property (
        req.valid |=> act.src[23:16] == $past(seg_q[eff][15:8]))
        else $error("source segment wrong");
    AST_DST_ADDR: assert property (
        req.valid |=> act.dst[23:16] == $past(seg_q[eff][7:0]))
        else $error("destination segment wrong");
    AST_TRAP: assert property (
        act_d.xfer && !cc[10] && (src_q[eff][0] || dst_q[eff][0])
        |=> act.trap)
        else $error("odd word pointer did not trap");
    AST_ENABLE: assert property (
        req.valid && !odd_blocked && cnt != 8'h00 |=> act.xfer)
        else $error("enabled channel did not transfer");
endmodule

// ==== hw/etc_pkg.sv ====
// Purpose: Constants and types for the event transfer channel controller
// Assumes: Eight channels, linked as fixed even/odd pairs
// Notes: Register map offsets are byte addresses on AXI4-Lite
package etc_pkg;
    localparam int NUM_CH = 8;
    // Register offsets, one block of 0x20 per channel
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] SRC_OFS = 12'h004;
    localparam logic [11:0] DST_OFS = 12'h008;
    localparam logic [11:0] SEG_OFS = 12'h00C;
    localparam logic [11:0] CH_STRIDE = 12'h020;
    localparam logic [11:0] SUBNODE_OFS = 12'h100;
    localparam logic [11:0] ENDNODE_OFS = 12'h104;
    localparam logic [11:0] STATUS_OFS = 12'h108;
    // Control register field positions
    localparam int CNT_LSB = 0;
    localparam int INC_LSB = 8;
    localparam int BWS_BIT = 10;
    localparam int EOT_BIT = 11;
    localparam int LINK_BIT = 12;
    // Reset values and count constants
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [15:0] SEG_RST = 16'h0000;
    localparam logic [7:0] CNT_CONT = 8'hFF;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [15:0] SAT_BYTE = 16'hFFFF;
    localparam logic [15:0] SAT_WORD = 16'hFFFE;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Request from interrupt arbitration
    typedef struct packed {
        logic valid;
        logic [2:0] chan;
    } etc_req_t;

    // Outcome of one serviced request
    typedef struct packed {
        logic valid;
        logic xfer;
        logic keep_req;
        logic normal_irq;
        logic word;
        logic trap;
        logic [23:0] src;
        logic [23:0] dst;
    } etc_act_t;
endpackage

// ==== tb/etc_arb_model.sv ====
// Purpose: Arbitration side model issuing one request pulse per go
// Assumes: Bench raises go for one cycle per wanted request
// Notes: Channel lines change while idle so stale values never match
`timescale 1ns/1ps
module etc_arb_model
(
    input wire logic clk,
    input wire logic reset,
    input wire logic go,
    input wire logic [2:0] go_chan,
    output etc_pkg::etc_req_t req
);
    // One winner pulse per go, channel scrambled between requests
    always_ff @(posedge clk)
    begin
        req.valid <= go && !reset;
        req.chan <= reset ? 3'h0 : (go ? go_chan : ~req.chan);
    end
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the event transfer channel control
// Assumes: AXI4-Lite master tasks and a request model on the far side
// Notes: Expected results are worked out by hand from channel settings
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, go = 1'b0;
    logic [2:0] go_chan = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, eot_req;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    etc_pkg::etc_req_t req;
    etc_pkg::etc_act_t act;
    etc_pkg::etc_act_t got;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;

    etc_ctrl i_etc_ctrl (.clk(clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .req(req),
        .act(act), .end_transfer_node_request(eot_req));

    etc_arb_model i_etc_arb_model (.clk(clk), .reset(reset), .go(go),
        .go_chan(go_chan), .req(req));

    // Free running clock, 25 ns period
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            stop_test();
        end
    end

    task stop_test;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    function logic [11:0] ca(input int n, input logic [11:0] o);
        return o + 12'(n) * etc_pkg::CH_STRIDE;
    endfunction

    // Control word: link, end select, byte select, inc, count
    function logic [31:0] cw(input logic l, input logic e, input logic b,
        input logic [1:0] inc, input logic [7:0] cnt);
        return {19'h0, l, e, b, inc, cnt};
    endfunction

    // Write: address and data offered together, each released when taken
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, na, nw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw))
        begin
            @(negedge clk);
            na = awready;
            nw = wready;
            @(posedge clk);
            if (na === 1'b1 && !ta)
            begin
                awvalid <= 1'b0;
                ta = 1'b1;
            end
            if (nw === 1'b1 && !tw)
            begin
                wvalid <= 1'b0;
                tw = 1'b1;
            end
        end
        bready <= 1'b1;
        do @(negedge clk); while (bvalid !== 1'b1);
        rs = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task rdr(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask

    // Request; f = {xfer, keep_req, normal_irq, trap}
    task rq(input logic [2:0] c, input logic [3:0] f, input logic [23:0] s,
        input logic [23:0] d);
        etc_pkg::etc_act_t a;
        int i;
        a = '0;
        go <= 1'b1;
        go_chan <= c;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 8 && a.valid !== 1'b1; i++)
        begin
            @(negedge clk);
            if (act.valid === 1'b1)
                a = act;
        end
        @(posedge clk);
        got = a;
        chk("act.valid", 32'h1, 32'(a.valid));
        chk("act.flags", 32'(f), 32'({a.xfer, a.keep_req, a.normal_irq,
            a.trap}));
        if (f[3])
        begin
            chk("act.src", 32'(s), 32'(a.src));
            chk("act.dst", 32'(d), 32'(a.dst));
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdr(ca(0, etc_pkg::CTRL_OFS));
        chk("ctrl0", 32'h0, rd);
        rdr(ca(7, etc_pkg::DST_OFS));
        chk("dst7", 32'h0, rd);
        rdr(ca(7, etc_pkg::SEG_OFS));
        chk("seg7", 32'h0, rd);
        rdr(12'hFFC);
        chk("resp", 32'(etc_pkg::RESP_SLVERR), 32'(rs));
        // Word channel, both pointers stepping
        wr(ca(2, etc_pkg::SEG_OFS), 32'h0000A5C3);
        wr(ca(2, etc_pkg::SRC_OFS), 32'h00001000);
        wr(ca(2, etc_pkg::DST_OFS), 32'h00002002);
        wr(ca(2, etc_pkg::CTRL_OFS), cw(0, 0, 0, 2'h3, 8'h03));
        rq(2, 4'h8, 24'hA51000, 24'hC32002);
        chk("act.word", 32'h1, 32'(got.word));
        rq(2, 4'h8, 24'hA51002, 24'hC32004);
        rq(2, 4'hC, 24'hA51004, 24'hC32006);
        rdr(ca(2, etc_pkg::CTRL_OFS));
        chk("ctrl2", cw(0, 0, 0, 2'h3, 8'h00), rd);
        rq(2, 4'h2, 24'h0, 24'h0);
        // Byte channel at the top of its segment, end select set
        wr(etc_pkg::SUBNODE_OFS, 32'h00000040);
        wr(ca(3, etc_pkg::SRC_OFS), 32'h0000FFFF);
        wr(ca(3, etc_pkg::CTRL_OFS), cw(0, 1, 1, 2'h2, 8'h02));
        rq(3, 4'h8, 24'h00FFFF, 24'h0);
        chk("act.word", 32'h0, 32'(got.word));
        chk("eot_req", 32'h0, 32'(eot_req));
        rq(3, 4'h8, 24'h00FFFF, 24'h0);
        chk("eot_req", 32'h1, 32'(eot_req));
        rq(3, 4'h2, 24'h0, 24'h0);
        rdr(etc_pkg::SUBNODE_OFS);
        chk("subnode", 32'h000000C0, rd);
        wr(etc_pkg::ENDNODE_OFS, 32'h0);
        chk("bresp", 32'(etc_pkg::RESP_OKAY), 32'(rs));
        wr(etc_pkg::STATUS_OFS, 32'h1);
        chk("bresp", 32'(etc_pkg::RESP_SLVERR), 32'(rs));
        wr(etc_pkg::SUBNODE_OFS, 32'h0);
        chk("eot_req", 32'h0, 32'(eot_req));
        rdr(etc_pkg::SUBNODE_OFS);
        chk("subnode", 32'h0, rd);
        // Odd word pointer, no increment
        wr(ca(4, etc_pkg::SRC_OFS), 32'h00000011);
        wr(ca(4, etc_pkg::CTRL_OFS), cw(0, 0, 0, 2'h0, 8'h02));
        rq(4, 4'h9, 24'h000011, 24'h0);
        rq(4, 4'hD, 24'h000011, 24'h0);
        // Continuous count, word destination parked at its ceiling
        wr(ca(5, etc_pkg::DST_OFS), 32'h0000FFFE);
        wr(ca(5, etc_pkg::CTRL_OFS), cw(0, 0, 0, 2'h1, 8'hFF));
        rq(5, 4'h8, 24'h000000, 24'h00FFFE);
        rq(5, 4'h8, 24'h000000, 24'h00FFFE);
        rdr(ca(5, etc_pkg::CTRL_OFS));
        chk("ctrl5", cw(0, 0, 0, 2'h1, 8'hFF), rd);
        // Linked pair 0/1; the last channel is left unlinked
        wr(ca(0, etc_pkg::SRC_OFS), 32'h00000100);
        wr(ca(0, etc_pkg::CTRL_OFS), cw(1, 0, 0, 2'h0, 8'h01));
        wr(ca(1, etc_pkg::SRC_OFS), 32'h00000200);
        wr(ca(1, etc_pkg::CTRL_OFS), cw(0, 0, 0, 2'h0, 8'h02));
        rq(1, 4'h2, 24'h0, 24'h0);
        rq(0, 4'h8, 24'h000100, 24'h0);
        rq(0, 4'h8, 24'h000200, 24'h0);
        rdr(etc_pkg::STATUS_OFS);
        chk("status", 32'h1, rd);
        rq(0, 4'hC, 24'h000200, 24'h0);
        rdr(etc_pkg::STATUS_OFS);
        chk("status", 32'h0, rd);
        rq(0, 4'h2, 24'h0, 24'h0);
        rdr(etc_pkg::SUBNODE_OFS);
        chk("subnode", 32'h00000002, rd);
        stop_test();
    end
endmodule
